// [verilog/sbwt_top.sv]
// Purpose: power-down mode select, settle wait and watch clock sampling rate
// Assumes: sleep_exec and wake_irq are synchronous one-cycle pulses
// Notes:   pclk is the system clock; apb slave answers in the first access cycle
`timescale 1ns/1ps
`include "sbwt_consts.svh"

module sbwt_top #(
  parameter logic [17:0] WAIT_C0 = `SBWT_WAIT_C0,
  parameter logic [17:0] WAIT_C1 = `SBWT_WAIT_C1,
  parameter logic [17:0] WAIT_C2 = `SBWT_WAIT_C2,
  parameter logic [17:0] WAIT_C3 = `SBWT_WAIT_C3,
  parameter logic [17:0] WAIT_C4 = `SBWT_WAIT_C4
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core events
  input  wire logic        sleep_exec,
  input  wire logic        wake_irq,
  input  wire logic        watch_clk,
  // power state and watch clock sampler outputs
  output logic [2:0]       mode,
  output logic             cpu_hold,
  output logic             periph_hold,
  output logic             watch_sample,
  output logic             watch_clk_filt
);

  sbwt_wait_if wt ();

  sbwt_wake_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .wt      (wt)
  );

  // wait code to state count
  function automatic logic [17:0] sbwt_wait_len(input logic [2:0] code);
    unique case (code)
      3'h0: sbwt_wait_len = WAIT_C0;
      3'h1: sbwt_wait_len = WAIT_C1;
      3'h2: sbwt_wait_len = WAIT_C2;
      3'h3: sbwt_wait_len = WAIT_C3;
      3'h4: sbwt_wait_len = WAIT_C4;
      3'h5: sbwt_wait_len = `SBWT_WAIT_C5;
      3'h6: sbwt_wait_len = `SBWT_WAIT_C6;
      3'h7: sbwt_wait_len = `SBWT_WAIT_C7;
    endcase
  endfunction : sbwt_wait_len

  // register storage
  logic [7:0]  ctrl1_q, ctrl1_d;
  logic [2:0]  ctrl2_q, ctrl2_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        setup, wr_acc, hit;
  logic [31:0] rd_word;

  // control fields
  logic        standby_select, sleep_kind_select, low_speed_flag, direct_transfer_flag, noise_filter_rate_select;
  logic [2:0]  wsel;

  assign standby_select  = ctrl1_q[`SBWT_STANDBY_SELECT_BIT];
  assign wsel  = ctrl1_q[`SBWT_WSEL_HI:`SBWT_WSEL_LO];
  assign noise_filter_rate_select = ctrl1_q[`SBWT_NOISE_FILTER_RATE_SELECT_BIT];
  assign sleep_kind_select = ctrl2_q[2];
  assign low_speed_flag  = ctrl2_q[1];
  assign direct_transfer_flag  = ctrl2_q[0];

  // mode and hold state
  sbwt_pkg::sbwt_mode_t mode_q, mode_d;
  logic        cpu_hold_q, cpu_hold_d;
  logic        per_hold_q, per_hold_d;
  logic        start_q, start_d;
  logic [17:0] count_q, count_d;

  // watch clock sampler state
  logic [3:0]  ndiv_q, ndiv_d;
  logic        samp_q, samp_d;
  logic        wfilt_q, wfilt_d;

  // apb decode and read mux
  always_comb begin
    setup = psel && !penable;
    hit   = (paddr == `SBWT_OFS_CTRL1) || (paddr == `SBWT_OFS_CTRL2) || (paddr == `SBWT_OFS_STATUS);
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `SBWT_OFS_CTRL1:  rd_word[7:0] = ctrl1_q & `SBWT_CTRL1_WMASK;
      `SBWT_OFS_CTRL2:  rd_word[7:5] = ctrl2_q;
      `SBWT_OFS_STATUS: rd_word[5:0] = {wt.busy, per_hold_q, cpu_hold_q, mode_q};
      default:          rd_word = 32'h0000_0000;
    endcase
    wr_acc = psel && penable && pready_q && pwrite && !pslverr_q;
  end

  // apb answer one cycle after setup
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup ? !hit : pslverr_q;
    prdata_d  = setup ? rd_word : prdata_q;
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    if (wr_acc && paddr == `SBWT_OFS_CTRL1) begin
      ctrl1_d = pwdata[7:0] & `SBWT_CTRL1_WMASK;
    end
    if (wr_acc && paddr == `SBWT_OFS_CTRL2) begin
      ctrl2_d = pwdata[7:5];
    end
  end

  // register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q   <= `SBWT_CTRL1_RST;
      ctrl2_q   <= `SBWT_CTRL2_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // mode transitions on sleep instruction, waking interrupt and settle wait done
  always_comb begin
    mode_d  = mode_q;
    start_d = 1'b0;
    count_d = count_q;
    unique case (mode_q)
      sbwt_pkg::SBWT_ACTIVE: begin
        if (sleep_exec) begin
          if (standby_select && !direct_transfer_flag) mode_d = sbwt_pkg::SBWT_STANDBY;
          else if (direct_transfer_flag && low_speed_flag) mode_d = sbwt_pkg::SBWT_SUBACTIVE;
          else if (sleep_kind_select && low_speed_flag) mode_d = sbwt_pkg::SBWT_SUBSLEEP;
          else mode_d = sbwt_pkg::SBWT_SLEEP;
        end
      end
      sbwt_pkg::SBWT_SUBACTIVE: begin
        if (sleep_exec) begin
          if (standby_select && !direct_transfer_flag) mode_d = sbwt_pkg::SBWT_STANDBY;
          else if (direct_transfer_flag && !low_speed_flag) mode_d = sbwt_pkg::SBWT_SETTLE;
          else mode_d = sbwt_pkg::SBWT_SUBSLEEP;
        end
      end
      sbwt_pkg::SBWT_SLEEP: begin
        if (wake_irq) mode_d = sbwt_pkg::SBWT_ACTIVE;
      end
      sbwt_pkg::SBWT_STANDBY, sbwt_pkg::SBWT_SUBSLEEP: begin
        if (wake_irq) mode_d = low_speed_flag ? sbwt_pkg::SBWT_SUBACTIVE : sbwt_pkg::SBWT_SETTLE;
      end
      sbwt_pkg::SBWT_SETTLE: begin
        if (wt.done) mode_d = sbwt_pkg::SBWT_ACTIVE;
      end
      default: mode_d = sbwt_pkg::SBWT_ACTIVE;
    endcase
    if (mode_d == sbwt_pkg::SBWT_SETTLE && mode_q != sbwt_pkg::SBWT_SETTLE) begin
      start_d = 1'b1;
      count_d = sbwt_wait_len(wsel);
    end
    cpu_hold_d = mode_d != sbwt_pkg::SBWT_ACTIVE && mode_d != sbwt_pkg::SBWT_SUBACTIVE;
    per_hold_d = mode_d == sbwt_pkg::SBWT_STANDBY || mode_d == sbwt_pkg::SBWT_SETTLE;
  end

  // mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= sbwt_pkg::SBWT_ACTIVE;
      start_q    <= 1'b0;
      count_q    <= 18'h0_0010;
      cpu_hold_q <= 1'b0;
      per_hold_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      start_q    <= start_d;
      count_q    <= count_d;
      cpu_hold_q <= cpu_hold_d;
      per_hold_q <= per_hold_d;
    end
  end

  assign wt.start = start_q;
  assign wt.count = count_q;

  // watch clock sample strobe at osc/16 or osc/4
  always_comb begin
    samp_d  = 1'b0;
    wfilt_d = wfilt_q;
    if (ndiv_q == '0) begin
      ndiv_d  = noise_filter_rate_select ? `SBWT_NDIV_FAST : `SBWT_NDIV_SLOW;
      samp_d  = 1'b1;
      wfilt_d = watch_clk;
    end else begin
      ndiv_d = ndiv_q - 4'h1;
    end
  end

  // sampler registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ndiv_q  <= 4'h0;
      samp_q  <= 1'b0;
      wfilt_q <= 1'b0;
    end else begin
      ndiv_q  <= ndiv_d;
      samp_q  <= samp_d;
      wfilt_q <= wfilt_d;
    end
  end

  // outputs straight from flops
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign mode           = mode_q;
  assign cpu_hold       = cpu_hold_q;
  assign periph_hold    = per_hold_q;
  assign watch_sample   = samp_q;
  assign watch_clk_filt = wfilt_q;

endmodule : sbwt_top

// [inc/sbwt_consts.svh]
// Purpose: offsets, field positions, reset values and counts of the standby control block
// Assumes: 32-bit apb data, byte addresses, one register per aligned word
// Notes:   definitions only
`ifndef SBWT_CONSTS_SVH
`define SBWT_CONSTS_SVH

// register byte offsets
`define SBWT_OFS_CTRL1        8'h00
`define SBWT_OFS_CTRL2        8'h04
`define SBWT_OFS_STATUS       8'h08

// power_down_control_one fields
`define SBWT_STANDBY_SELECT_BIT         7
`define SBWT_WSEL_HI          6
`define SBWT_WSEL_LO          4
`define SBWT_NOISE_FILTER_RATE_SELECT_BIT        3
`define SBWT_CTRL1_RST        8'h00
`define SBWT_CTRL1_WMASK      8'hF8

// power_down_control_two fields kept here
`define SBWT_SLEEP_KIND_SELECT_BIT        7
`define SBWT_LOW_SPEED_FLAG_BIT         6
`define SBWT_DIRECT_TRANSFER_FLAG_BIT         5
`define SBWT_CTRL2_RST        3'h0

// settle wait lengths in system clock states
`define SBWT_WAIT_C0          18'h0_2000
`define SBWT_WAIT_C1          18'h0_4000
`define SBWT_WAIT_C2          18'h0_8000
`define SBWT_WAIT_C3          18'h1_0000
`define SBWT_WAIT_C4          18'h2_0000
`define SBWT_WAIT_C5          18'h0_0400
`define SBWT_WAIT_C6          18'h0_0080
`define SBWT_WAIT_C7          18'h0_0010
`define SBWT_CNT_W            18

// watch clock sampling dividers
`define SBWT_NDIV_SLOW        4'hF
`define SBWT_NDIV_FAST        4'h3

`endif

// [inc/sbwt_pkg.sv]
// Purpose: types shared by the standby control block
// Assumes: nothing
// Notes:   gray codes along active-sleep-standby-settle path
package sbwt_pkg;

  typedef enum logic [2:0] {
    SBWT_ACTIVE    = 3'h0,
    SBWT_SLEEP     = 3'h1,
    SBWT_STANDBY   = 3'h3,
    SBWT_SETTLE    = 3'h2,
    SBWT_SUBSLEEP  = 3'h6,
    SBWT_SUBACTIVE = 3'h4
  } sbwt_mode_t;

endpackage : sbwt_pkg

// [inc/sbwt_wait_if.sv]
// Purpose: link between mode control and the settle wait timer
// Assumes: single pclk domain
// Notes:   start is a one-cycle pulse, count held while busy
`timescale 1ns/1ps
interface sbwt_wait_if;
  logic        start;
  logic [17:0] count;
  logic        busy;
  logic        done;

  modport ctrl  (output start, output count, input busy, input done);
  modport timer (input start, input count, output busy, output done);
endinterface : sbwt_wait_if

// [verilog/sbwt_wake_timer.sv]
// Purpose: counts the oscillator settle wait in system clock states
// Assumes: count is at least one
// Notes:   done pulses count plus one cycles after the start edge
`timescale 1ns/1ps
`include "sbwt_consts.svh"
module sbwt_wake_timer (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // control side
  sbwt_wait_if.timer      wt
);

  logic [`SBWT_CNT_W-1:0] cnt_q, cnt_d;
  logic                   busy_q, busy_d;
  logic                   done_q, done_d;

  // next count, loads on start and runs down to zero
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (wt.start) begin
      cnt_d  = wt.count - 18'h0_0001;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 18'h0_0001;
      end
    end
  end

  // timer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign wt.busy = busy_q;
  assign wt.done = done_q;

endmodule : sbwt_wake_timer

// [dv/sbwt_properties.sv]
// Purpose: port checks for the standby control block
// Assumes: one clock, async active-low reset
// Notes:   shadows control writes to know the codes
`timescale 1ns/1ps
module sbwt_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core events and state
  input wire logic        sleep_exec,
  input wire logic        wake_irq,
  input wire logic        watch_clk,
  input wire logic [2:0]  mode,
  input wire logic        cpu_hold,
  input wire logic        periph_hold,
  input wire logic        watch_sample,
  input wire logic        watch_clk_filt
);
  logic [7:0] c1_q, c1_d;
  logic [2:0] c2_q, c2_d;
  logic       skip_q, skip_d;
  logic       rate_q, rate_d;
  logic       prev_q, prev_d;
  logic [4:0] cnt_q, cnt_d;
  logic       wr;
  // shadow of control writes, sample spacing
  assign wr = psel && penable && pready && pwrite;
  always_comb begin
    c1_d   = (wr && paddr == 8'h00) ? pwdata[7:0] : c1_q;
    c2_d   = (wr && paddr == 8'h04) ? pwdata[7:5] : c2_q;
    skip_d = skip_q && !watch_sample;
    cnt_d  = watch_sample ? 5'h00 : cnt_q + 5'h01;
    // rate in force at the reload that launched this pulse
    prev_d = c1_q[3];
    rate_d = watch_sample ? prev_q : rate_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      {c1_q, c2_q, skip_q, cnt_q, rate_q, prev_q} <= {11'h000, 1'b1, 5'h00, 2'h0};
    else
      {c1_q, c2_q, skip_q, cnt_q, rate_q, prev_q} <= {c1_d, c2_d, skip_d, cnt_d, rate_d, prev_d};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_NO_STBY: assert property (mode == 3'h0 && sleep_exec && !c1_q[7] |=> mode != 3'h3)
    else $error("standby entered with select clear");
  AST_STBY: assert property (mode == 3'h0 && sleep_exec && c1_q[7] && !c2_q[0] |=> mode == 3'h3)
    else $error("standby not entered");
  AST_SETTLE_HOLD: assert property (mode == 3'h2 |-> cpu_hold && periph_hold)
    else $error("holds low in settle wait");
  AST_ACT_FREE: assert property (mode == 3'h0 |-> !cpu_hold && !periph_hold)
    else $error("holds high in active");
  AST_WAKE: assert property ((mode == 3'h3 || mode == 3'h6) && wake_irq && !c2_q[1] |=> mode == 3'h2)
    else $error("wake did not start settle");
  AST_WAIT16: assert property ($rose(mode == 3'h2) && c1_q[6:4] == 3'h7 |->
    (mode == 3'h2)[*8] ##1 (mode == 3'h2)[*8] ##1 (mode == 3'h2)[*2] ##1 mode == 3'h0)
    else $error("shortest settle wait wrong");
  AST_RATE: assert property (watch_sample && !skip_q |-> cnt_q == (rate_q ? 5'h03 : 5'h0F))
    else $error("sample spacing wrong");
  AST_FILT: assert property (watch_sample |-> watch_clk_filt == $past(watch_clk))
    else $error("filtered clock not captured");
  AST_RSVD: assert property (psel && penable && pready && !pwrite && paddr == 8'h00 |->
    prdata == {24'h00_0000, c1_q[7:3], 3'h0})
    else $error("control read wrong");
  AST_SUBACT: assert property ((mode == 3'h3 || mode == 3'h6) && wake_irq && c2_q[1] |=> mode == 3'h4)
    else $error("wake did not reach subactive");
endmodule : sbwt_chk

bind sbwt_top sbwt_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .sleep_exec, .wake_irq, .watch_clk, .mode, .cpu_hold, .periph_hold,
  .watch_sample, .watch_clk_filt);

// [dv/tb_standby_control_wake_timer.sv]
// Purpose: directed bench for the standby control block
// Assumes: apb answers in the first access cycle
// Notes:   long settle counts shortened by parameters
`timescale 1ns/1ps
module tb_standby_control_wake_timer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sleep_exec, wake_irq, watch_clk, cpu_hold, periph_hold;
  logic        watch_sample, watch_clk_filt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  mode;
  int          err_count, n_tests, cyc, n;
  int          wt[8] = '{40, 50, 60, 70, 80, 1024, 128, 16};

  sbwt_top #(.WAIT_C0(40), .WAIT_C1(50), .WAIT_C2(60), .WAIT_C3(70), .WAIT_C4(80)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_exec, .wake_irq, .watch_clk, .mode, .cpu_hold, .periph_hold, .watch_sample,
    .watch_clk_filt);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer, error flag expected above status
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pslverr}, {31'h0, a > 8'h08});
    if (!w) chk(prdata, e);
  endtask : bus

  // one-cycle event pulse, then mode check
  task automatic ev(input logic s, input logic w, input logic [2:0] m);
    @(posedge pclk);
    sleep_exec <= s;
    wake_irq   <= w;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    wake_irq   <= 1'b0;
    @(negedge pclk);
    chk({29'h0, mode}, {29'h0, m});
  endtask : ev

  // spacing of sample pulses, first gap skipped
  task automatic gap(input int e);
    repeat (2) begin
      do @(negedge pclk); while (watch_sample !== 1'b1);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (watch_sample !== 1'b1);
    end
    chk(n, e);
  endtask : gap

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // cycle ceiling
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sleep_exec, wake_irq, watch_clk} = 7'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0, 32'h0);
    bus(1'b1, 8'h00, 32'h0000_00FF, 32'h0);
    bus(1'b0, 8'h00, 32'h0, 32'h0000_00F8);
    bus(1'b0, 8'h0C, 32'h0, 32'h0);
    bus(1'b1, 8'h08, 32'h0000_00FF, 32'h0);
    bus(1'b0, 8'h08, 32'h0, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h00, {24'h00_0000, 1'b1, 3'(k), 4'h0}, 32'h0);
      ev(1'b1, 1'b0, 3'h3);
      ev(1'b0, 1'b1, 3'h2);
      n = 1;
      do begin
        @(negedge pclk);
        n++;
      end while (mode === 3'h2);
      chk(n, wt[k] + 3);
      chk({29'h0, mode}, 32'h0);
    end
    $display("test settle done");
    bus(1'b1, 8'h00, 32'h0, 32'h0);
    ev(1'b0, 1'b1, 3'h0);
    ev(1'b1, 1'b0, 3'h1);
    chk({30'h0, cpu_hold, periph_hold}, 32'h2);
    bus(1'b0, 8'h08, 32'h0, 32'h0000_0009);
    ev(1'b0, 1'b1, 3'h0);
    bus(1'b1, 8'h04, 32'h0000_00C0, 32'h0);
    bus(1'b0, 8'h04, 32'h0, 32'h0000_00C0);
    ev(1'b1, 1'b0, 3'h6);
    ev(1'b0, 1'b1, 3'h4);
    ev(1'b1, 1'b0, 3'h6);
    ev(1'b0, 1'b1, 3'h4);
    bus(1'b1, 8'h04, 32'h0000_0020, 32'h0);
    ev(1'b1, 1'b0, 3'h2);
    do @(negedge pclk); while (mode === 3'h2);
    chk({29'h0, mode}, 32'h0);
    bus(1'b1, 8'h04, 32'h0000_0060, 32'h0);
    bus(1'b1, 8'h00, 32'h0000_0080, 32'h0);
    ev(1'b1, 1'b0, 3'h4);
    $display("test modes done");
    @(posedge pclk);
    watch_clk <= 1'b1;
    gap(16);
    bus(1'b1, 8'h00, 32'h0000_0008, 32'h0);
    gap(4);
    chk({31'h0, watch_clk_filt}, 32'h1);
    $display("test sampling done");
    give_verdict();
  end
endmodule : tb_standby_control_wake_timer
